/* smg_consts.vh */
// Constants for the standby-mode peripheral gating controller.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef SMG_CONSTS_VH
`define SMG_CONSTS_VH
`define SMG_ADDR_W        8
`define SMG_OFF_CTRL      8'h00
`define SMG_OFF_CMD       8'h04
`define SMG_OFF_EDGE      8'h08
`define SMG_OFF_STATUS    8'h0C
`define SMG_OFF_ACK       8'h10
`define SMG_CTRL_W        18
`define SMG_CTRL_RST      18'h00000
`define SMG_EDGE_W        20
`define SMG_EDGE_RST      20'h00000
`define SMG_B_WTCS        0
`define SMG_B_LPRTC       1
`define SMG_B_WDTEN       2
`define SMG_B_WDTSR       3
`define SMG_B_ONSUB       4
`define SMG_B_EXSSEL      5
`define SMG_B_STEN0       6
`define SMG_B_STEN2       7
`define SMG_B_RSEL0       8
`define SMG_B_RSEL1       9
`define SMG_B_BYP         10
`define SMG_B_XTEN        16
`define SMG_B_EXSEN       17
`define SMG_B_CRISE       0
`define SMG_B_CFALL       8
`define SMG_B_ERISE       16
`define SMG_B_EFALL       18
`define SMG_B_CMD_HALT    0
`define SMG_B_CMD_STOP    1
`define SMG_ST_RUN        2'h0
`define SMG_ST_HALT       2'h1
`define SMG_ST_STOP       2'h2
`define SMG_ST_SNOOZE     2'h3
`define SMG_NUM_IRQ       41
`define SMG_NUM_CMP       6
`define SMG_CMP_WAKE_CAP  6'h05
`endif

/* smg_standby_ctrl.v */
// Standby-mode controller: HALT/STOP/SNOOZE sequencing, clock and peripheral
// gating, comparator gating and maskable-interrupt priority selection.
// Assumes pclk at 10 MHz; pins cmp_out and ext_irq are asynchronous.
//
// What this block does
// - Simultaneous pending maskable interrupts are served lowest index first, 0 to 40.
// - Comparator channels one, three, four and five never release STOP.
// - In STOP only comparators zero and two run, needing wake enable and bypass.
// - Subsystem HALT: only comparators zero and two; low-power RTC adds enable and bypass.
// - Low-speed oscillator runs on wake-timer select, or watchdog on with standby run.
// - HALT or STOP gates the CPU clock off and stops execution.
// - STOP keeps port latches and subsystem clock state; main clocks stop.
// - Subsystem HALT: timer array runs only while low-power RTC mode is 0.
// - In STOP the ADC trigger stays armed and moves the device to SNOOZE.
// - Subsystem HALT: selected subsystem source runs, the other cannot run.
// - Subsystem HALT: ADC disabled, amplifier may run with no consumer.
// - External inputs twenty and twenty-one route per timer trigger setup; comparators never reach the timer restart.
// - Restart-selected external input feeds the timer restart and never releases STOP.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`default_nettype none
`include "smg_consts.vh"
module smg_standby_ctrl #(
   parameter NUM_IRQ = `SMG_NUM_IRQ,
   parameter NUM_CMP = `SMG_NUM_CMP
) (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [7:0]            paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   input  wire [NUM_IRQ-1:0]    irq_req,
   input  wire [NUM_CMP-1:0]    cmp_out,
   input  wire [1:0]            ext_irq,
   input  wire                  adc_trigger,
   input  wire                  adc_done,
   output reg                   cpu_clk_en_ff,
   output reg                   main_osc_en_ff,
   output reg                   subsys_xt_en_ff,
   output reg                   subsys_ext_en_ff,
   output reg                   low_speed_osc_en_ff,
   output reg                   port_hold_ff,
   output reg                   timer_array_en_ff,
   output reg                   adc_en_ff,
   output reg                   adc_wake_en_ff,
   output reg                   pga_en_ff,
   output reg  [NUM_CMP-1:0]    cmp_run_ff,
   output reg  [NUM_CMP-1:0]    comparator_interrupt_ff,
   output reg  [1:0]            ext_irq_out_ff,
   output reg  [1:0]            timer_restart_ff,
   output reg  [5:0]            irq_vector_ff,
   output reg                   irq_valid_ff,
   output reg  [1:0]            state_ff
);

   reg  [`SMG_CTRL_W-1:0] ctrl_ff;
   reg  [`SMG_EDGE_W-1:0] edge_ff;
   reg  [NUM_IRQ-1:0]     pend_ff;
   reg                    halt_sub_ff;
   reg  [NUM_CMP-1:0]     cmp_s1_ff;
   reg  [NUM_CMP-1:0]     cmp_s2_ff;
   reg  [NUM_CMP-1:0]     cmp_s3_ff;
   reg  [1:0]             ext_s1_ff;
   reg  [1:0]             ext_s2_ff;
   reg  [1:0]             ext_s3_ff;
   reg  [1:0]             nxt_state;
   wire [NUM_IRQ-1:0]     ack_mask;
   reg  [5:0]             nxt_vec;
   reg                    nxt_valid;
   reg  [31:0]            nxt_rdata;
   reg                    nxt_err;
   wire [NUM_CMP-1:0]     cmp_elig;
   wire [NUM_CMP-1:0]     cmp_evt;
   wire [NUM_CMP-1:0]     cmp_next;
   wire                   sub_next;
   wire [1:0]             ext_evt;
   wire                   wr_acc;
   wire                   setup;
   wire                   cmd_halt;
   wire                   cmd_stop;
   wire                   lprtc;
   wire                   in_stop;
   wire                   in_sub_halt;
   wire                   cmp_wake;
   wire                   ext_wake;
   wire                   any_pend;
   wire                   loco_stby;
   integer                i;

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready & pwrite;
   assign cmd_halt = wr_acc & (paddr == `SMG_OFF_CMD) & pwdata[`SMG_B_CMD_HALT];
   assign cmd_stop = wr_acc & (paddr == `SMG_OFF_CMD) & pwdata[`SMG_B_CMD_STOP];
   assign lprtc = ctrl_ff[`SMG_B_LPRTC];
   assign in_stop = (state_ff == `SMG_ST_STOP) | (state_ff == `SMG_ST_SNOOZE);
   assign in_sub_halt = (state_ff == `SMG_ST_HALT) & halt_sub_ff;
   assign any_pend = |pend_ff;
   assign sub_next = (nxt_state == `SMG_ST_HALT) & ((state_ff == `SMG_ST_RUN) ? ctrl_ff[`SMG_B_ONSUB] : halt_sub_ff);
   assign ack_mask = {{(NUM_IRQ-1){1'b0}}, wr_acc & (paddr == `SMG_OFF_ACK)} << pwdata[5:0];
   // Per-channel eligibility and event detection.
   genvar n;
   generate
      for (n = 0; n < NUM_CMP; n = n + 1) begin : g_cmp
         wire cap;
         wire sten;
         wire qual;
         wire rise;
         wire fall;
         assign cap  = (n == 0) | (n == 2);
         assign sten = (n == 0) ? ctrl_ff[`SMG_B_STEN0] : (n == 2) ? ctrl_ff[`SMG_B_STEN2] : 1'b0;
         assign qual = cap & sten & ctrl_ff[`SMG_B_BYP + n];
         assign rise = cmp_s2_ff[n] & ~cmp_s3_ff[n];
         assign fall = ~cmp_s2_ff[n] & cmp_s3_ff[n];
         assign cmp_elig[n] = in_stop ? qual :
                              in_sub_halt ? (cap & (~lprtc | qual)) :
                              1'b1;
         assign cmp_next[n] = nxt_state[1] ? qual :
                              sub_next ? (cap & (~lprtc | qual)) : 1'b1;
         assign cmp_evt[n] = sten ? rise :
                             ((rise & edge_ff[`SMG_B_CRISE + n]) |
                              (fall & edge_ff[`SMG_B_CFALL + n]));
      end
   endgenerate
   assign cmp_wake = |(cmp_evt & cmp_elig & `SMG_CMP_WAKE_CAP);
   assign ext_evt = ((ext_s2_ff & ~ext_s3_ff) & edge_ff[`SMG_B_ERISE +: 2]) |
                    ((~ext_s2_ff & ext_s3_ff) & edge_ff[`SMG_B_EFALL +: 2]);
   assign ext_wake = |(ext_evt & ~ctrl_ff[`SMG_B_RSEL0 +: 2]);
   assign loco_stby = ctrl_ff[`SMG_B_WTCS] |
                      (ctrl_ff[`SMG_B_WDTEN] & ctrl_ff[`SMG_B_WDTSR]);
   // Standby state sequencing.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `SMG_ST_RUN: begin
            if (cmd_stop) begin
               nxt_state = `SMG_ST_STOP;
            end else if (cmd_halt) begin
               nxt_state = `SMG_ST_HALT;
            end
         end
         `SMG_ST_HALT: begin
            if (any_pend | cmp_wake | ext_wake) begin
               nxt_state = `SMG_ST_RUN;
            end
         end
         `SMG_ST_STOP: begin
            if (any_pend | cmp_wake | ext_wake) begin
               nxt_state = `SMG_ST_RUN;
            end else if (adc_trigger) begin
               nxt_state = `SMG_ST_SNOOZE;
            end
         end
         `SMG_ST_SNOOZE: begin
            if (any_pend | cmp_wake | ext_wake) begin
               nxt_state = `SMG_ST_RUN;
            end else if (adc_done) begin
               nxt_state = `SMG_ST_STOP;
            end
         end
         default: begin
            nxt_state = `SMG_ST_RUN;
         end
      endcase
   end
   // Fixed priority: the lowest pending index wins.
   always @* begin
      nxt_vec = 6'h00;
      nxt_valid = 1'b0;
      for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
         if (pend_ff[i]) begin
            nxt_vec = i[5:0];
            nxt_valid = 1'b1;
         end
      end
   end

   // Read mux and unmapped-address detection.
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_err = 1'b0;
      case (paddr)
         `SMG_OFF_CTRL: begin
            nxt_rdata[`SMG_CTRL_W-1:0] = ctrl_ff;
         end
         `SMG_OFF_CMD, `SMG_OFF_ACK: begin
            nxt_rdata = 32'h00000000;
         end
         `SMG_OFF_EDGE: begin
            nxt_rdata[`SMG_EDGE_W-1:0] = edge_ff;
         end
         `SMG_OFF_STATUS: begin
            nxt_rdata[1:0] = state_ff;
            nxt_rdata[2] = halt_sub_ff;
            nxt_rdata[13:8] = irq_vector_ff;
            nxt_rdata[14] = irq_valid_ff;
            nxt_rdata[21:16] = cmp_run_ff;
         end
         default: begin
            nxt_err = 1'b1;
         end
      endcase
   end
   // Bus slave: one wait-free access phase after each setup cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ctrl_ff <= `SMG_CTRL_RST;
         edge_ff <= `SMG_EDGE_RST;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : nxt_rdata;
            pslverr <= nxt_err;
         end else begin
            pslverr <= 1'b0;
         end
         if (wr_acc && (paddr == `SMG_OFF_CTRL)) begin
            ctrl_ff <= pwdata[`SMG_CTRL_W-1:0];
         end
         if (wr_acc && (paddr == `SMG_OFF_EDGE)) begin
            edge_ff <= pwdata[`SMG_EDGE_W-1:0];
         end
      end
   end

   // Input synchronisers and the pending flags; a new request beats its clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_s1_ff <= {NUM_CMP{1'b0}};
         cmp_s2_ff <= {NUM_CMP{1'b0}};
         cmp_s3_ff <= {NUM_CMP{1'b0}};
         ext_s1_ff <= 2'h0;
         ext_s2_ff <= 2'h0;
         ext_s3_ff <= 2'h0;
         pend_ff <= {NUM_IRQ{1'b0}};
         irq_vector_ff <= 6'h00;
         irq_valid_ff <= 1'b0;
      end else begin
         cmp_s1_ff <= cmp_out;
         cmp_s2_ff <= cmp_s1_ff;
         cmp_s3_ff <= cmp_s2_ff;
         ext_s1_ff <= ext_irq;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
         pend_ff <= (pend_ff & ~ack_mask) | irq_req;
         irq_vector_ff <= nxt_vec;
         irq_valid_ff <= nxt_valid;
      end
   end

   // State register and interrupt routing outputs.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= `SMG_ST_RUN;
         halt_sub_ff <= 1'b0;
         comparator_interrupt_ff <= {NUM_CMP{1'b0}};
         cmp_run_ff <= {NUM_CMP{1'b1}};
         ext_irq_out_ff <= 2'h0;
         timer_restart_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         if ((state_ff == `SMG_ST_RUN) && cmd_halt && !cmd_stop) begin
            halt_sub_ff <= ctrl_ff[`SMG_B_ONSUB];
         end
         comparator_interrupt_ff <= cmp_evt & cmp_next;
         cmp_run_ff <= cmp_next;
         ext_irq_out_ff <= ext_evt & ~ctrl_ff[`SMG_B_RSEL0 +: 2];
         timer_restart_ff <= ext_evt & ctrl_ff[`SMG_B_RSEL0 +: 2];
      end
   end

   // Clock and peripheral gating per state.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clk_en_ff <= 1'b1;
         main_osc_en_ff <= 1'b1;
         subsys_xt_en_ff <= 1'b0;
         subsys_ext_en_ff <= 1'b0;
         low_speed_osc_en_ff <= 1'b1;
         port_hold_ff <= 1'b0;
         timer_array_en_ff <= 1'b1;
         adc_en_ff <= 1'b1;
         adc_wake_en_ff <= 1'b0;
         pga_en_ff <= 1'b1;
      end else begin
         cpu_clk_en_ff <= (nxt_state == `SMG_ST_RUN);
         port_hold_ff <= (nxt_state != `SMG_ST_RUN);
         low_speed_osc_en_ff <= (nxt_state == `SMG_ST_RUN) | loco_stby;
         pga_en_ff <= 1'b1;
         case (nxt_state)
            `SMG_ST_RUN: begin
               main_osc_en_ff <= 1'b1;
               subsys_xt_en_ff <= ctrl_ff[`SMG_B_XTEN];
               subsys_ext_en_ff <= ctrl_ff[`SMG_B_EXSEN];
               timer_array_en_ff <= 1'b1;
               adc_en_ff <= 1'b1;
               adc_wake_en_ff <= 1'b0;
            end
            `SMG_ST_HALT: begin
               if (sub_next) begin
                  main_osc_en_ff <= 1'b0;
                  subsys_xt_en_ff <= ~ctrl_ff[`SMG_B_EXSSEL];
                  subsys_ext_en_ff <= ctrl_ff[`SMG_B_EXSSEL];
                  timer_array_en_ff <= ~lprtc;
                  adc_en_ff <= 1'b0;
               end else begin
                  main_osc_en_ff <= 1'b1;
                  timer_array_en_ff <= 1'b1;
                  adc_en_ff <= 1'b1;
               end
               adc_wake_en_ff <= 1'b0;
            end
            `SMG_ST_STOP: begin
               main_osc_en_ff <= 1'b0;
               timer_array_en_ff <= 1'b0;
               adc_en_ff <= 1'b0;
               adc_wake_en_ff <= 1'b1;
            end
            default: begin
               main_osc_en_ff <= 1'b1;
               timer_array_en_ff <= 1'b0;
               adc_en_ff <= 1'b1;
               adc_wake_en_ff <= 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* smg_props.sv */
// Checker for the standby controller, bound to it and watching only its ports.
// Assumes one clock, pclk, and the active-low asynchronous reset presetn.
`default_nettype none
module smg_props #(
   parameter NUM_CMP = 6
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic               pready,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [1:0]         state_ff,
   input wire logic               cpu_clk_en_ff,
   input wire logic               main_osc_en_ff,
   input wire logic               subsys_xt_en_ff,
   input wire logic               subsys_ext_en_ff,
   input wire logic               low_speed_osc_en_ff,
   input wire logic               port_hold_ff,
   input wire logic               timer_array_en_ff,
   input wire logic               adc_en_ff,
   input wire logic               adc_wake_en_ff,
   input wire logic [NUM_CMP-1:0] cmp_run_ff,
   input wire logic [NUM_CMP-1:0] comparator_interrupt_ff,
   input wire logic [1:0]         ext_irq_out_ff,
   input wire logic [1:0]         timer_restart_ff
);
   logic [17:0] ctrl_ff;
   wire logic   sub_halt = state_ff == 2'h1 && ctrl_ff[4];
   // Shadow of the control word, taken at the edge where an APB write lands.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_ff <= 18'h00000;
      else if (psel && penable && pready && pwrite && paddr == 8'h00)
         ctrl_ff <= pwdata[17:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_cpu_gate: assert property (cpu_clk_en_ff == (state_ff == 2'h0))
      else $error("cpu clock enable does not follow the run state");
   a_stop_hold: assert property (
      state_ff == 2'h2 |-> !main_osc_en_ff && port_hold_ff && $stable(subsys_xt_en_ff) && $stable(subsys_ext_en_ff))
      else $error("stop state lost a held clock or latch");
   a_stop_adc: assert property (state_ff[1] |-> adc_wake_en_ff && adc_en_ff == state_ff[0])
      else $error("converter wake path wrong in stop or snooze");
   a_stop_cmp: assert property (state_ff[1] |-> !(|(cmp_run_ff & 6'h3A)))
      else $error("odd comparator running in stop");
   a_sub_halt: assert property (
      sub_halt |-> !(|(cmp_run_ff & 6'h3A)) && timer_array_en_ff == !ctrl_ff[1] && !adc_en_ff && !main_osc_en_ff)
      else $error("subsystem halt gating wrong");
   a_sub_source: assert property (sub_halt |-> subsys_xt_en_ff == !ctrl_ff[5] && subsys_ext_en_ff == ctrl_ff[5])
      else $error("subsystem source selection wrong in halt");
   a_lso_standby: assert property (state_ff != 2'h0 |-> low_speed_osc_en_ff == (ctrl_ff[0] || ctrl_ff[2] && ctrl_ff[3]))
      else $error("low-speed oscillator enable wrong in standby");
   a_cmp_gated: assert property (|comparator_interrupt_ff |-> !(|(comparator_interrupt_ff & ~cmp_run_ff)) &&
      !(state_ff[1] && |(comparator_interrupt_ff & 6'h3A)))
      else $error("interrupt from an ineligible comparator");
   a_ext_route: assert property (
      |{ext_irq_out_ff, timer_restart_ff} |-> !(|(ext_irq_out_ff & ctrl_ff[9:8])) && !(|(timer_restart_ff & ~ctrl_ff[9:8])))
      else $error("external input routed to the wrong function");
endmodule
bind smg_standby_ctrl smg_props #(.NUM_CMP(NUM_CMP)) u_props (.*);
`default_nettype wire

/* smg_periph_model.sv */
// Far-side model: interrupt sources, comparator and external pins, and an A/D converter.
// Assumes the bench calls its tasks; a conversion ends dly cycles into SNOOZE.
`default_nettype none
module smg_periph_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        adc_en_ff,
   input  wire logic        adc_wake_en_ff,
   output var  logic [40:0] irq_req,
   output var  logic [5:0]  cmp_out,
   output var  logic [1:0]  ext_irq,
   output var  logic        adc_trigger,
   output var  logic        adc_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int dly = 1;
   int cnt;
   initial begin
      irq_req = 41'h0;
      cmp_out = 6'h00;
      ext_irq = 2'h0;
      adc_trigger = 1'h0;
   end
   task automatic irq(input logic [40:0] m);
      @(posedge pclk);
      irq_req <= m;
      @(posedge pclk);
      irq_req <= 41'h0;
   endtask
   task automatic pins(input logic [5:0] c, input logic [1:0] e, input logic t);
      @(posedge pclk);
      cmp_out <= c;
      ext_irq <= e;
      adc_trigger <= t;
   endtask
   // The converter only runs in SNOOZE, where both enables are high.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         adc_done <= 1'h0;
      end else if (adc_en_ff && adc_wake_en_ff && !adc_done) begin
         cnt <= cnt + 1;
         adc_done <= cnt + 1 == dly;
      end else begin
         cnt <= 0;
         adc_done <= 1'h0;
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Bench for the standby controller: APB master, a table of standby cases and directed cases.
// Assumes the peripheral model drives the far-side pins and the checker is bound to the controller.
`default_nettype none
`include "smg_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, adc_trigger, adc_done;
   logic        cpu_clk_en_ff, main_osc_en_ff, subsys_xt_en_ff, subsys_ext_en_ff, low_speed_osc_en_ff;
   logic        port_hold_ff, timer_array_en_ff, adc_en_ff, adc_wake_en_ff, pga_en_ff, irq_valid_ff;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [40:0] irq_req;
   logic [5:0]  cmp_out, cmp_run_ff, comparator_interrupt_ff, irq_vector_ff;
   logic [1:0]  ext_irq, ext_irq_out_ff, timer_restart_ff, state_ff;
   logic [9:0]  seen;
   int          bad_count, n_compared, cyc;
   // Row: control word, command, then state, low-speed oscillator, timer array, comparator enables.
   logic [29:0] rows [9] = '{
      {18'h00000, 2'h1, 2'h1, 1'h0, 1'h1, 6'h3F},
      {18'h00001, 2'h2, 2'h2, 1'h1, 1'h0, 6'h00},
      {18'h00004, 2'h3, 2'h2, 1'h0, 1'h0, 6'h00},
      {18'h0000C, 2'h2, 2'h2, 1'h1, 1'h0, 6'h00},
      {18'h014C0, 2'h2, 2'h2, 1'h0, 1'h0, 6'h05},
      {18'h0FC40, 2'h2, 2'h2, 1'h0, 1'h0, 6'h01},
      {18'h10010, 2'h1, 2'h1, 1'h0, 1'h1, 6'h05},
      {18'h110D2, 2'h1, 2'h1, 1'h0, 1'h0, 6'h04},
      {18'h20030, 2'h1, 2'h1, 1'h0, 1'h1, 6'h05}};
   logic [6:0]  prio [4] = '{7'h40, 7'h4C, 7'h68, 7'h00};
   smg_standby_ctrl dut_u (.*);
   smg_periph_model per_u (.*);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         #1;
         seen = seen | {timer_restart_ff, ext_irq_out_ff, comparator_interrupt_ff};
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_st(input logic [1:0] s);
      tick(1);
      for (int i = 0; i < 30 && state_ff !== s; i++) tick(1);
      chk("state", s, state_ff);
   endtask
   task automatic wake(input int idx);
      per_u.irq(41'h1 << idx);
      wait_st(2'h0);
      apb(1'h1, `SMG_OFF_ACK, idx);
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seen = 10'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `SMG_OFF_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'h1, `SMG_OFF_EDGE, 32'hFFFFFFFF);
      apb(1'h0, `SMG_OFF_EDGE, 32'h0);
      chk("edge width", 32'h000FFFFF, rd);
      apb(1'h0, 8'h14, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      foreach (rows[i]) begin
         apb(1'h1, `SMG_OFF_CTRL, {14'h0, rows[i][29:12]});
         apb(1'h1, `SMG_OFF_CMD, {30'h0, rows[i][11:10]});
         tick(1);
         chk("standby", rows[i][9:0], {state_ff, low_speed_osc_en_ff, timer_array_en_ff, cmp_run_ff});
         wake(i);
      end
      per_u.irq(41'h10000001001);
      foreach (prio[i]) begin
         apb(1'h0, `SMG_OFF_STATUS, 32'h0);
         chk("pending order", prio[i], rd[14:8]);
         chk("vector port", prio[i], {irq_valid_ff, irq_vector_ff});
         apb(1'h1, `SMG_OFF_ACK, prio[i][5:0]);
      end
      apb(1'h1, `SMG_OFF_EDGE, 32'h3F);
      apb(1'h1, `SMG_OFF_CTRL, 32'hFCC0);
      apb(1'h1, `SMG_OFF_CMD, 32'h2);
      seen = 10'h0;
      per_u.pins(6'h3A, 2'h0, 1'h0);
      tick(10);
      chk("odd comparators", 32'h0, {seen, state_ff == 2'h2 ? 2'h0 : 2'h3});
      per_u.pins(6'h3B, 2'h0, 1'h0);
      wait_st(2'h0);
      tick(2);
      chk("comparator zero", 10'h001, seen);
      per_u.pins(6'h00, 2'h0, 1'h0);
      apb(1'h1, `SMG_OFF_EDGE, 32'h30000);
      apb(1'h1, `SMG_OFF_CTRL, 32'h100);
      apb(1'h1, `SMG_OFF_CMD, 32'h2);
      seen = 10'h0;
      per_u.pins(6'h00, 2'h1, 1'h0);
      tick(10);
      chk("restart input", 12'h402, {seen, state_ff});
      seen = 10'h0;
      per_u.pins(6'h00, 2'h3, 1'h0);
      wait_st(2'h0);
      tick(2);
      chk("ext input", 10'h080, seen);
      per_u.pins(6'h00, 2'h0, 1'h0);
      apb(1'h1, `SMG_OFF_CTRL, 32'h10000);
      for (int d = 1; d < 8; d += 5) begin
         per_u.dly = d;
         apb(1'h1, `SMG_OFF_CMD, 32'h2);
         tick(1);
         chk("stop hold", 3'h7, {subsys_xt_en_ff, port_hold_ff, adc_wake_en_ff});
         chk("stop clocks", 3'h1, {subsys_ext_en_ff, main_osc_en_ff, pga_en_ff});
         per_u.pins(6'h00, 2'h0, 1'h1);
         per_u.pins(6'h00, 2'h0, 1'h0);
         wait_st(2'h3);
         chk("snooze adc", 1'h1, adc_en_ff);
         wait_st(2'h2);
         wake(5);
      end
      apb(1'h1, `SMG_OFF_CMD, 32'h1);
      tick(1);
      chk("halt cpu gate", 3'h2, {state_ff, cpu_clk_en_ff});
      @(posedge pclk);
      presetn <= 1'h0;
      tick(2);
      chk("reset", 6'h0B, {state_ff, cpu_clk_en_ff, port_hold_ff, pga_en_ff, main_osc_en_ff});
      @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `SMG_OFF_CTRL, 32'h0);
      chk("ctrl after reset", 32'h0, rd);
      give_verdict();
   end
endmodule
`default_nettype wire
